// [scooter_drive_interlock.sv]
// Top level of the scooter drive interlock
`timescale 1ns/10ps
module scooter_drive_interlock
  import sdi_pkg::*;
#(
  parameter int HOLD_CYC = DEBOUNCE_CYC,
  parameter int WAIT_CYC = BRAKE_WAIT_CYC,
  parameter int LEAD_CYC = REL_LEAD_CYC,
  parameter int FLASH_HALF_CYC = FLASH_CYC,
  parameter int READY_CYC = STATUS_CYC
)
(
  // Clock and reset; reset stands for power-up
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Tiller switches, low when grounded
  input wire logic slow_n_i,
  input wire logic freewheel_n_i,
  // Charger connector
  input wire logic inhibit_pin_i,
  input wire logic charger_present_i,
  input wire logic [sdi_pkg::CUR_W-1:0] charge_current_i,
  // Configuration
  input wire logic inhibit_mode_i,
  input wire logic inhibit_latched_i,
  input wire logic [sdi_pkg::SPD_W-1:0] max_speed_i,
  input wire logic [sdi_pkg::SPD_W-1:0] slow_speed_i,
  input wire logic [sdi_pkg::SPD_W-1:0] norm_accel_i,
  input wire logic [sdi_pkg::SPD_W-1:0] slow_accel_i,
  input wire logic [sdi_pkg::SPD_W-1:0] norm_decel_i,
  input wire logic [sdi_pkg::SPD_W-1:0] slow_decel_i,
  // Drive demand and faults
  input wire logic demand_i,
  input wire logic trip_i,
  input wire logic low_batt_i,
  // Drive limits
  output logic [sdi_pkg::SPD_W-1:0] speed_limit_o,
  output logic [sdi_pkg::SPD_W-1:0] accel_limit_o,
  output logic [sdi_pkg::SPD_W-1:0] decel_limit_o,
  output logic drive_en_o,
  output logic stop_o,
  // Brake and status
  output logic brake_release_o,
  output logic freewheel_o,
  output logic inhibited_o,
  output logic status_led_o,
  output logic [sdi_pkg::DISP_W-1:0] charge_disp_o
);
  sdi_sw_if sw ();
  sdi_state_type state_ff;
  sdi_state_type nxt_state;
  logic [CNT_W-1:0] tmr_ff;
  logic [CNT_W-1:0] nxt_tmr;
  logic [CNT_W-1:0] flash_ff;
  logic [CNT_W-1:0] ready_ff;
  logic flash_ph_ff;
  logic trip_ff;
  logic trip_s1_ff;
  logic trip_s2_ff;
  logic latch_ff;
  logic [DISP_W-1:0] step_ff;
  logic [SPD_W-1:0] speed_ff;
  logic [SPD_W-1:0] accel_ff;
  logic [SPD_W-1:0] decel_ff;
  logic drive_ff;
  logic release_ff;
  logic stop_ff;
  logic fw_ff;
  logic inh_ff;
  logic led_ff;
  logic [DISP_W-1:0] disp_ff;

  function automatic logic [SPD_W-1:0] sdi_fw_scale(input logic [SPD_W-1:0] v);
    logic [SPD_W+1:0] p;
    p = {2'b00, v} * {{SPD_W{1'b0}}, FW_NUM};
    return SPD_W'(p >> FW_SHIFT);
  endfunction : sdi_fw_scale

  sdi_front #(.HOLD_CYC(HOLD_CYC)) u_front (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .slow_n_i(slow_n_i),
    .freewheel_n_i(freewheel_n_i),
    .inhibit_pin_i(inhibit_pin_i),
    .sw(sw.src)
  );

  // Inhibit and drive act on switch levels only after the power-up delay, which must outlast the
  // debounce; a debouncer's reset level could otherwise pass for an inhibit and latch it
  wire logic status_ok = ready_ff == CNT_ZERO;
  // Inhibit level per mode: mode one means a grounded pin is active
  wire logic pin_inh = inhibit_mode_i ? sw.inhibit_pin_low : ~sw.inhibit_pin_low;
  wire logic inh_raw = status_ok & pin_inh;
  wire logic inh_now = inh_raw | latch_ff;
  wire logic fw_ok = sw.freewheel & ~trip_ff & ~inh_now;
  wire logic can_drive = status_ok & demand_i & ~inh_now & ~trip_ff & ~sw.freewheel;
  wire logic tmr_done = tmr_ff == CNT_ZERO;
  wire logic [SPD_W-1:0] base_speed = sw.slow ? slow_speed_i : max_speed_i;
  wire logic [SPD_W-1:0] base_accel = sw.slow ? slow_accel_i : norm_accel_i;
  wire logic [SPD_W-1:0] norm_dec = sw.slow ? slow_decel_i : norm_decel_i;
  wire logic [SPD_W-1:0] fw_speed = sdi_fw_scale(max_speed_i);
  wire logic [DISP_W-1:0] meas_level = DISP_W'(charge_current_i >> DISP_SHIFT);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_tmr = tmr_done ? CNT_ZERO : tmr_ff - CNT_ONE;
    unique case (state_ff)
      SDI_PARK:
        if (can_drive)
        begin
          nxt_state = SDI_RELEASE;
          nxt_tmr = CNT_W'(LEAD_CYC);
        end
      SDI_RELEASE:
        if (!can_drive)
        begin
          nxt_state = SDI_PARK;
        end
        else if (tmr_done)
        begin
          nxt_state = SDI_DRIVE;
        end
      SDI_DRIVE:
        if (!can_drive)
        begin
          nxt_state = SDI_HOLD;
          nxt_tmr = CNT_W'(WAIT_CYC);
        end
      SDI_HOLD:
        if (can_drive)
        begin
          nxt_state = SDI_DRIVE;
        end
        else if (tmr_done)
        begin
          nxt_state = SDI_PARK;
        end
      default:
        nxt_state = SDI_PARK;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= SDI_PARK;
      tmr_ff <= CNT_ZERO;
    end
    else
    begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
    end
  end

  // Trip is sticky until power-up; pin is synchronised first
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      trip_s1_ff <= 1'b0;
      trip_s2_ff <= 1'b0;
      trip_ff <= 1'b0;
      latch_ff <= 1'b0;
    end
    else
    begin
      trip_s1_ff <= trip_i;
      trip_s2_ff <= trip_s1_ff;
      trip_ff <= trip_ff | trip_s2_ff;
      latch_ff <= latch_ff | (inh_raw & inhibit_latched_i);
    end
  end

  // Status indicator timing and charge display stepping
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_ff <= CNT_W'(READY_CYC);
      flash_ff <= CNT_ZERO;
      flash_ph_ff <= 1'b0;
      step_ff <= DISP_ZERO;
    end
    else
    begin
      ready_ff <= status_ok ? CNT_ZERO : ready_ff - CNT_ONE;
      if (flash_ff == CNT_ZERO)
      begin
        flash_ff <= CNT_W'(FLASH_HALF_CYC);
        flash_ph_ff <= ~flash_ph_ff;
        step_ff <= (step_ff == DISP_FULL) ? DISP_ZERO : step_ff + DISP_ONE;
      end
      else
      begin
        flash_ff <= flash_ff - CNT_ONE;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      speed_ff <= SPD_ZERO;
      accel_ff <= SPD_ZERO;
      decel_ff <= SPD_ZERO;
      drive_ff <= 1'b0;
      release_ff <= 1'b0;
      stop_ff <= 1'b1;
      fw_ff <= 1'b0;
      inh_ff <= 1'b0;
      led_ff <= 1'b0;
      disp_ff <= DISP_ZERO;
    end
    else
    begin
      speed_ff <= fw_ok ? fw_speed : base_speed;
      accel_ff <= base_accel;
      decel_ff <= norm_dec;
      drive_ff <= nxt_state == SDI_DRIVE;
      release_ff <= fw_ok | (nxt_state != SDI_PARK);
      stop_ff <= inh_now | ~can_drive;
      fw_ff <= fw_ok;
      inh_ff <= inh_now;
      led_ff <= status_ok & (low_batt_i ? flash_ph_ff : 1'b1);
      if (inh_raw && inhibit_latched_i)
        disp_ff <= step_ff;
      else if (charger_present_i)
        disp_ff <= meas_level;
      else
        disp_ff <= DISP_ZERO;
    end
  end

  assign speed_limit_o = speed_ff;
  assign accel_limit_o = accel_ff;
  assign decel_limit_o = decel_ff;
  assign drive_en_o = drive_ff;
  assign brake_release_o = release_ff;
  assign stop_o = stop_ff;
  assign freewheel_o = fw_ff;
  assign inhibited_o = inh_ff;
  assign status_led_o = led_ff;
  assign charge_disp_o = disp_ff;
endmodule : scooter_drive_interlock

// [sdi_pkg.sv]
// Package of constants and types for the scooter drive interlock
package sdi_pkg;
  // Timing figures in their own units and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int DEBOUNCE_US = 10000;
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int STATUS_MS = 500;
  localparam int STATUS_CYC = (STATUS_MS * 1000 - 1) * CLK_MHZ;
  localparam int BRAKE_WAIT_MS = 2000;
  localparam int BRAKE_WAIT_CYC = BRAKE_WAIT_MS * 1000 * CLK_MHZ;
  localparam int REL_LEAD_MS = 100;
  localparam int REL_LEAD_CYC = REL_LEAD_MS * 1000 * CLK_MHZ;
  localparam int FLASH_MS = 500;
  localparam int FLASH_CYC = FLASH_MS * 1000 * CLK_MHZ;
  localparam int SPD_W = 8;
  localparam int CNT_W = 32;
  localparam int CUR_W = 8;
  localparam int DISP_W = 4;
  localparam logic [SPD_W-1:0] SPD_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [DISP_W-1:0] DISP_ZERO = 4'h0;
  localparam logic [DISP_W-1:0] DISP_ONE = 4'h1;
  localparam logic [DISP_W-1:0] DISP_FULL = 4'hF;
  localparam int DISP_SHIFT = 4;
  localparam logic [1:0] FW_NUM = 2'h3;
  localparam int FW_SHIFT = 2;
  // Drive states
  typedef enum logic [3:0] {
    SDI_PARK = 4'h1,
    SDI_RELEASE = 4'h2,
    SDI_DRIVE = 4'h4,
    SDI_HOLD = 4'h8
  } sdi_state_type;
endpackage : sdi_pkg

// [sdi_sw_if.sv]
// Interface carrying debounced switch levels
`timescale 1ns/10ps
interface sdi_sw_if;
  logic slow;
  logic freewheel;
  logic inhibit_pin_low;
  modport src (output slow, output freewheel, output inhibit_pin_low);
  modport dst (input slow, input freewheel, input inhibit_pin_low);
endinterface : sdi_sw_if

// [sdi_debounce.sv]
// Synchroniser and debouncer for one active-low switch
`timescale 1ns/10ps
module sdi_debounce
  import sdi_pkg::*;
#(
  parameter int HOLD_CYC = 1000000
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Switch pin and clean level
  input wire logic pin_n_i,
  output logic active_o
);
  logic sync1_ff;
  logic sync2_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic active_ff;
  wire logic raw_active = ~sync2_ff;
  wire logic differs = raw_active != active_ff;
  wire logic settled = cnt_ff >= CNT_W'(HOLD_CYC);
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      sync1_ff <= 1'b1;
      sync2_ff <= 1'b1;
      cnt_ff <= CNT_ZERO;
      active_ff <= 1'b0;
    end
    else
    begin
      sync1_ff <= pin_n_i;
      sync2_ff <= sync1_ff;
      cnt_ff <= differs ? cnt_ff + CNT_ONE : CNT_ZERO;
      if (differs && settled)
        active_ff <= raw_active;
    end
  end
  assign active_o = active_ff;
endmodule : sdi_debounce

// [sdi_front.sv]
// Debounce front end for the tiller and charger switches
`timescale 1ns/10ps
module sdi_front
  import sdi_pkg::*;
#(
  parameter int HOLD_CYC = 1000000
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Raw pins, low when grounded
  input wire logic slow_n_i,
  input wire logic freewheel_n_i,
  input wire logic inhibit_pin_i,
  // Clean levels
  sdi_sw_if.src sw
);
  logic inh_low;
  sdi_debounce #(.HOLD_CYC(HOLD_CYC)) u_slow (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_n_i(slow_n_i), .active_o(sw.slow));
  sdi_debounce #(.HOLD_CYC(HOLD_CYC)) u_fw (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_n_i(freewheel_n_i), .active_o(sw.freewheel));
  sdi_debounce #(.HOLD_CYC(HOLD_CYC)) u_inh (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .pin_n_i(inhibit_pin_i), .active_o(inh_low));
  assign sw.inhibit_pin_low = inh_low;
endmodule : sdi_front

// [sdi_chk_assertions.sv]
// Port checker for the scooter drive interlock
`timescale 1ns/10ps
module sdi_chk
  import sdi_pkg::*;
#(
  parameter int WAIT_CYC = 20,
  parameter int LEAD_CYC = 5,
  parameter int READY_CYC = 10
)
(
  // Clock, reset and inputs
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic freewheel_n_i,
  input wire logic charger_present_i,
  input wire logic [sdi_pkg::CUR_W-1:0] charge_current_i,
  input wire logic inhibit_latched_i,
  input wire logic [sdi_pkg::SPD_W-1:0] max_speed_i,
  input wire logic demand_i,
  input wire logic trip_i,
  input wire logic low_batt_i,
  // Outputs watched
  input wire logic [sdi_pkg::SPD_W-1:0] speed_limit_o,
  input wire logic drive_en_o,
  input wire logic stop_o,
  input wire logic brake_release_o,
  input wire logic freewheel_o,
  input wire logic inhibited_o,
  input wire logic status_led_o,
  input wire logic [sdi_pkg::DISP_W-1:0] charge_disp_o
);
  logic [CNT_W-1:0] up_ff;
  logic [CNT_W-1:0] low_ff;
  logic [9:0] fw_spd;
  assign fw_spd = ({2'h0, max_speed_i} * 10'h003) >> 2;
  // Cycles since reset and since demand last dropped, both saturating
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      up_ff <= CNT_ZERO;
      low_ff <= CNT_ZERO;
    end
    else
    begin
      up_ff <= (up_ff < 32'h0000FFFF) ? up_ff + CNT_ONE : up_ff;
      low_ff <= demand_i ? CNT_ZERO : (low_ff < CNT_W'(WAIT_CYC + 8)) ? low_ff + CNT_ONE : low_ff;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  sequence chg_idle;
    charger_present_i && !inhibited_o;
  endsequence
  fw_speed_a: assert property (freewheel_o && $stable(max_speed_i) |-> speed_limit_o == fw_spd[7:0])
    else $error("freewheel speed limit wrong");
  trip_fw_a: assert property (trip_i |-> ##5 !freewheel_o)
    else $error("freewheel accepted after trip");
  inh_stop_a: assert property (inhibited_o |-> stop_o && !drive_en_o)
    else $error("drive while inhibited");
  drive_lead_a: assert property ($rose(drive_en_o) |-> $past(brake_release_o, LEAD_CYC))
    else $error("drive without brake lead");
  drive_brake_a: assert property (drive_en_o |-> brake_release_o)
    else $error("drive with brake applied");
  led_ready_a: assert property (up_ff >= CNT_W'(READY_CYC + 3) && !low_batt_i && !$past(low_batt_i)
    |-> status_led_o)
    else $error("status led not lit");
  brake_hold_a: assert property (low_ff == CNT_W'(WAIT_CYC + 6) && freewheel_n_i && !freewheel_o
    |-> !brake_release_o)
    else $error("brake not re-engaged");
  disp_cur_a: assert property (chg_idle ##1 chg_idle |-> charge_disp_o == $past(charge_current_i[7:4]))
    else $error("charge display wrong");
  latch_hold_a: assert property (inhibited_o && inhibit_latched_i |=> inhibited_o)
    else $error("latched inhibit dropped");
endmodule : sdi_chk

bind scooter_drive_interlock sdi_chk #(.WAIT_CYC(WAIT_CYC), .LEAD_CYC(LEAD_CYC), .READY_CYC(READY_CYC)) u_chk (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .freewheel_n_i(freewheel_n_i),
  .charger_present_i(charger_present_i), .charge_current_i(charge_current_i),
  .inhibit_latched_i(inhibit_latched_i), .max_speed_i(max_speed_i), .demand_i(demand_i),
  .trip_i(trip_i), .low_batt_i(low_batt_i), .speed_limit_o(speed_limit_o),
  .drive_en_o(drive_en_o), .stop_o(stop_o), .brake_release_o(brake_release_o),
  .freewheel_o(freewheel_o), .inhibited_o(inhibited_o), .status_led_o(status_led_o),
  .charge_disp_o(charge_disp_o));

// [sdi_tiller_model.sv]
// Tiller switch model whose contacts bounce for three cycles on each change
`timescale 1ns/10ps
module sdi_tiller_model
(
  // Clock and wanted switch states
  input wire logic ref_clk_i,
  input wire logic slow_gnd_i,
  input wire logic fw_gnd_i,
  input wire logic inh_level_i,
  // Pins, low when grounded
  output logic slow_n_o,
  output logic freewheel_n_o,
  output logic inhibit_pin_o
);
  logic [2:0] want;
  logic [2:0] last_ff = 3'h7;
  logic [2:0] pin_ff = 3'h7;
  logic [2:0] flip_ff = 3'h0;
  logic [1:0] bnc_ff = 2'h0;
  assign want = {~slow_gnd_i, ~fw_gnd_i, inh_level_i};
  assign {slow_n_o, freewheel_n_o, inhibit_pin_o} = pin_ff;
  always @(posedge ref_clk_i)
  begin
    if (want != last_ff)
    begin
      bnc_ff <= 2'h3;
      flip_ff <= want ^ last_ff;
    end
    else if (bnc_ff != 2'h0)
      bnc_ff <= bnc_ff - 2'h1;
    last_ff <= want;
    pin_ff <= (bnc_ff != 2'h0) ? pin_ff ^ flip_ff : want;
  end
endmodule : sdi_tiller_model

// [tb_top.sv]
// Self-checking bench for the scooter drive interlock
`timescale 1ns/10ps
module tb_top;
  import sdi_pkg::*;
  localparam int WAIT = 20;
  localparam int LEAD = 5;
  localparam int HOLD = 4;
  localparam int FLASH = 8;
  localparam int READY = 10;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic slow_g = 1'b0, fw_g = 1'b0, inh_lvl = 1'b1, chg = 1'b0, mode = 1'b1, latch = 1'b0;
  logic dmd = 1'b0, trip = 1'b0, slow_n, fw_n, inh_pin, drv, stp, brk, fwo, inh, led;
  logic lb = 1'b0;
  logic [7:0] cur = 8'h00, mx = 8'hA7, ss = 8'h40, spd, acc, dec;
  logic [3:0] disp;
  int miscompares = 0, n_tests = 0, cyc = 0;
  initial forever #5 ref_clk_i = ~ref_clk_i;
  sdi_tiller_model u_sw (.ref_clk_i(ref_clk_i), .slow_gnd_i(slow_g), .fw_gnd_i(fw_g),
    .inh_level_i(inh_lvl), .slow_n_o(slow_n), .freewheel_n_o(fw_n), .inhibit_pin_o(inh_pin));
  scooter_drive_interlock #(.HOLD_CYC(HOLD), .WAIT_CYC(WAIT), .LEAD_CYC(LEAD),
    .FLASH_HALF_CYC(FLASH), .READY_CYC(READY)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .slow_n_i(slow_n), .freewheel_n_i(fw_n), .inhibit_pin_i(inh_pin), .charger_present_i(chg),
    .charge_current_i(cur), .inhibit_mode_i(mode), .inhibit_latched_i(latch), .max_speed_i(mx),
    .slow_speed_i(ss), .norm_accel_i(8'h21), .slow_accel_i(8'h12), .norm_decel_i(8'h33),
    .slow_decel_i(8'h14), .demand_i(dmd), .trip_i(trip), .low_batt_i(lb),
    .speed_limit_o(spd), .accel_limit_o(acc), .decel_limit_o(dec), .drive_en_o(drv),
    .stop_o(stp), .brake_release_o(brk), .freewheel_o(fwo), .inhibited_o(inh),
    .status_led_o(led), .charge_disp_o(disp));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_sim
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step
  task automatic do_reset();
    rst_i = 1'b1;
    step(20);
    rst_i = 1'b0;
  endtask : do_reset
  task automatic t_power();
    logic ch;
    logic l0;
    do_reset();
    step(1);
    chk(led, 8'h00);
    chk(stp, 8'h01);
    step(14);
    chk(led, 8'h01);
    lb = 1'b1;
    step(2);
    l0 = led;
    ch = 1'b0;
    repeat (12)
    begin
      step(1);
      ch = ch | (led !== l0);
    end
    chk(ch, 8'h01);
    lb = 1'b0;
    step(2);
    chk(led, 8'h01);
    $display("power done");
  endtask : t_power
  task automatic t_slow();
    slow_g = 1'b1;
    step(4);
    chk(spd, 8'hA7);
    step(16);
    chk(spd, 8'h40);
    chk(acc, 8'h12);
    chk(dec, 8'h14);
    ss = 8'h2C;
    step(2);
    chk(spd, 8'h2C);
    slow_g = 1'b0;
    step(20);
    chk(acc, 8'h21);
    chk(dec, 8'h33);
    $display("slow done");
  endtask : t_slow
  task automatic t_fw();
    mx = 8'hFF;
    fw_g = 1'b1;
    step(20);
    chk(brk, 8'h01);
    chk(fwo, 8'h01);
    chk(spd, 8'hBF);
    fw_g = 1'b0;
    step(50);
    chk(brk, 8'h00);
    $display("freewheel done");
  endtask : t_fw
  task automatic t_drive();
    int n;
    slow_g = 1'b1;
    step(20);
    dmd = 1'b1;
    n = 0;
    while (drv !== 1'b1 && n < 30)
    begin
      step(1);
      n++;
    end
    chk(8'(n), 8'(LEAD + 2));
    chk(brk, 8'h01);
    dmd = 1'b0;
    step(2);
    chk(stp, 8'h01);
    chk(brk, 8'h01);
    step(WAIT + 5);
    chk(brk, 8'h00);
    slow_g = 1'b0;
    step(20);
    $display("drive done");
  endtask : t_drive
  task automatic t_chg();
    chg = 1'b1;
    cur = 8'hB5;
    step(4);
    chk(disp, 8'h0B);
    cur = 8'h3C;
    step(3);
    chk(disp, 8'h03);
    chg = 1'b0;
    step(3);
    chk(disp, 8'h00);
    $display("charger done");
  endtask : t_chg
  task automatic t_inh();
    logic [3:0] d;
    logic ch;
    dmd = 1'b1;
    step(12);
    inh_lvl = 1'b0;
    step(20);
    chk(inh, 8'h01);
    chk(drv, 8'h00);
    chk(stp, 8'h01);
    inh_lvl = 1'b1;
    step(20);
    chk(inh, 8'h00);
    mode = 1'b0;
    step(5);
    chk(inh, 8'h01);
    inh_lvl = 1'b0;
    step(20);
    chk(inh, 8'h00);
    dmd = 1'b0;
    latch = 1'b1;
    inh_lvl = 1'b1;
    step(20);
    d = disp;
    ch = 1'b0;
    repeat (20)
    begin
      step(1);
      ch = ch | (disp !== d);
    end
    chk(ch, 8'h01);
    inh_lvl = 1'b0;
    step(20);
    chk(inh, 8'h01);
    do_reset();
    step(2);
    chk(inh, 8'h00);
    step(10);
    chk(inh, 8'h00);
    latch = 1'b0;
    $display("inhibit done");
  endtask : t_inh
  task automatic t_trip();
    trip = 1'b1;
    step(5);
    fw_g = 1'b1;
    step(20);
    chk(brk, 8'h00);
    chk(fwo, 8'h00);
    fw_g = 1'b0;
    trip = 1'b0;
    $display("trip done");
  endtask : t_trip
  always @(posedge ref_clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      end_sim();
    end
  end
  initial
  begin
    t_power();
    t_slow();
    t_fw();
    t_drive();
    t_chg();
    t_inh();
    t_trip();
    end_sim();
  end
endmodule : tb_top
